// [shared/pwm_out_pkg.sv]
// Constants and register map of the PWM output stage and interrupt enables
// ****************************************
// Functional notes
// - Mask enable replaces waveform with mask data
// - Masked output follows its mask data bit
// - Polarity bit set inverts channel output
// - Output-enable clear tri-states the pin
// - Down-match interrupt enables at bits 29:24
// - Up-match interrupt enables at bits 21:16
// - Complementary: odd down-enables serve paired even
// - Complementary: odd up-enables serve paired even
// - Bit 8 enables channel 0 period interrupt
// - Bit 0 enables channel 0 zero interrupt
// - Complementary: odd enable bits read zero
// - Down-match flag set by hardware, W1C
// - Period flag set by hardware, W1C
// ****************************************
package pwm_out_pkg;

	localparam int NUM_CH = 6;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
	localparam logic [7:0] OFS_MASK_ENABLE = 8'hb8;
	localparam logic [7:0] OFS_MASK_DATA = 8'hbc;
	localparam logic [7:0] OFS_POLARITY = 8'hd4;
	localparam logic [7:0] OFS_PIN_ENABLE = 8'hd8;
	localparam logic [7:0] OFS_INT_ENABLE = 8'he0;
	localparam logic [7:0] OFS_INT_FLAGS = 8'he8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DOWN_LSB = 24;
	localparam int UP_LSB = 16;
	localparam int PERIOD_BIT = 8;
	localparam int ZERO_BIT = 0;
	localparam int COMP_MODE_BIT = 0;

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [5:0] CH_RESET = 6'h00;
	localparam logic [5:0] ODD_CH_MASK = 6'h2a;
	localparam logic [31:0] FLAG_MASK = 32'h3f3f_0101;

	typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage : pwm_out_pkg

// [shared/chan_cond_if.sv]
// Per-channel conditioning signals between the register file and the output path
`timescale 1ns/1ps
interface chan_cond_if #(parameter int N = 6);
	logic [N-1:0] wave;
	logic [N-1:0] mask_override_on;
	logic [N-1:0] mask_level_bit;
	logic [N-1:0] polarity_flip;
	logic [N-1:0] pin_drive_on;
	logic [N-1:0] pin_level;
	logic [N-1:0] pin_oe;

	modport regs (
		output wave,
		output mask_override_on,
		output mask_level_bit,
		output polarity_flip,
		output pin_drive_on,
		input pin_level,
		input pin_oe
	);

	modport path (
		input wave,
		input mask_override_on,
		input mask_level_bit,
		input polarity_flip,
		input pin_drive_on,
		output pin_level,
		output pin_oe
	);
endinterface : chan_cond_if

// [src/chan_conditioner.sv]
// Per-channel mask, polarity and pin enable path
`timescale 1ns/1ps
module chan_conditioner
	import pwm_out_pkg::*;
#(
	parameter int N = NUM_CH
) (
	chan_cond_if.path cc
);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			logic masked;
			assign masked = cc.mask_override_on[g] ? cc.mask_level_bit[g] : cc.wave[g];
			assign cc.pin_level[g] = masked ^ cc.polarity_flip[g];
			assign cc.pin_oe[g] = cc.pin_drive_on[g];
		end
	endgenerate

endmodule : chan_conditioner

// [src/event_flags.sv]
// Sticky event flags with write-one-to-clear and enable-gated request
`timescale 1ns/1ps
module event_flags
	import pwm_out_pkg::*;
#(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Events, clears, enables
	input wire logic [W-1:0] evt,
	input wire logic [W-1:0] clr,
	input wire logic [W-1:0] en,
	// State
	output logic [W-1:0] flags_r,
	output logic irq_r
);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_flag
			// Set wins over a clear in the same cycle
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					flags_r[g] <= 1'b0;
				end else if (evt[g]) begin
					flags_r[g] <= 1'b1;
				end else if (clr[g]) begin
					flags_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(flags_r & en);
		end
	end

endmodule : event_flags

// [src/pwm_output_stage.sv]
// Top of the PWM output stage: register file, conditioning and interrupt request
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module pwm_output_stage
	import pwm_out_pkg::*;
#(
	parameter int N = NUM_CH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,

	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,

	// Generated waveforms and counter events
	input wire logic [5:0] wave_in,
	input wire logic [5:0] up_match_evt,
	input wire logic [5:0] down_match_evt,
	input wire logic period_point_evt,
	input wire logic zero_point_evt,

	// Output pins
	output logic [5:0] pwm_out,
	output logic [5:0] pwm_oe,

	// Interrupt request
	output logic irq
);

	// ****************************************
	// Register state
	// ****************************************
	logic comp_mode_r;
	logic [5:0] mask_override_on_r;
	logic [5:0] mask_level_bit_r;
	logic [5:0] polarity_flip_r;
	logic [5:0] pin_drive_on_r;
	logic [5:0] down_match_irq_on_r;
	logic [5:0] up_match_irq_on_r;
	logic period_point_irq_on_r;
	logic zero_point_irq_on_r;

	logic [31:0] readdata_r;
	logic [31:0] readdata_nxt;
	logic waitrequest_r;
	bus_state_e bus_state_r;

	logic [5:0] pwm_out_r;
	logic [5:0] pwm_oe_r;

	logic [31:0] flags;
	logic flag_irq;

	// ****************************************
	// Bus handshake
	// ****************************************
	logic req;
	logic wr_fire;
	logic [31:0] wmask;
	logic [31:0] wdata_m;

	assign req = avs_read | avs_write;
	// Write commits only at the edge where waitrequest is seen low
	assign wr_fire = avs_write & (bus_state_r == BUS_ACK);
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Merge write data into a current value under the byte enables
	function automatic logic [31:0] merge(input logic [31:0] cur);
		merge = (cur & ~wmask) | (avs_writedata & wmask);
	endfunction : merge

	assign wdata_m = avs_writedata & wmask;

	// One cycle of wait on every access, then a single acknowledge cycle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus_state_r <= BUS_IDLE;
			waitrequest_r <= 1'b1;
		end else begin
			case (bus_state_r)
				BUS_IDLE: begin
					if (req) begin
						bus_state_r <= BUS_ACK;
						waitrequest_r <= 1'b0;
					end
				end
				BUS_ACK: begin
					bus_state_r <= BUS_IDLE;
					waitrequest_r <= 1'b1;
				end
				default: begin
					bus_state_r <= BUS_IDLE;
					waitrequest_r <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	logic [5:0] down_en_vis;
	logic [5:0] up_en_vis;

	// Odd enables are hidden while the channels are paired
	assign down_en_vis = comp_mode_r ? (down_match_irq_on_r & ~ODD_CH_MASK)
		: down_match_irq_on_r;
	assign up_en_vis = comp_mode_r ? (up_match_irq_on_r & ~ODD_CH_MASK)
		: up_match_irq_on_r;

	always_comb begin
		readdata_nxt = REG_RESET;
		case (avs_address)
			OFS_MODE_CTRL: begin
				readdata_nxt[COMP_MODE_BIT] = comp_mode_r;
			end
			OFS_MASK_ENABLE: begin
				readdata_nxt[5:0] = mask_override_on_r;
			end
			OFS_MASK_DATA: begin
				readdata_nxt[5:0] = mask_level_bit_r;
			end
			OFS_POLARITY: begin
				readdata_nxt[5:0] = polarity_flip_r;
			end
			OFS_PIN_ENABLE: begin
				readdata_nxt[5:0] = pin_drive_on_r;
			end
			OFS_INT_ENABLE: begin
				readdata_nxt[DOWN_LSB +: 6] = down_en_vis;
				readdata_nxt[UP_LSB +: 6] = up_en_vis;
				readdata_nxt[PERIOD_BIT] = period_point_irq_on_r;
				readdata_nxt[ZERO_BIT] = zero_point_irq_on_r;
			end
			OFS_INT_FLAGS: begin
				readdata_nxt = flags & FLAG_MASK;
			end
			default: begin
				readdata_nxt = REG_RESET;
			end
		endcase
	end

	// Read data is loaded as waitrequest drops and holds until the next read
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			readdata_r <= REG_RESET;
		end else if (bus_state_r == BUS_IDLE && avs_read) begin
			readdata_r <= readdata_nxt;
		end
	end

	// ****************************************
	// Register writes
	// ****************************************
	logic [31:0] mode_cur;
	logic [31:0] ch_mask_en_cur;
	logic [31:0] ch_mask_dat_cur;
	logic [31:0] ch_pol_cur;
	logic [31:0] ch_poen_cur;
	logic [31:0] inten_cur;

	assign mode_cur = {31'h0000_0000, comp_mode_r};
	assign ch_mask_en_cur = {26'h000_0000, mask_override_on_r};
	assign ch_mask_dat_cur = {26'h000_0000, mask_level_bit_r};
	assign ch_pol_cur = {26'h000_0000, polarity_flip_r};
	assign ch_poen_cur = {26'h000_0000, pin_drive_on_r};
	assign inten_cur = {2'b00, down_match_irq_on_r, 2'b00, up_match_irq_on_r,
		7'h00, period_point_irq_on_r, 7'h00, zero_point_irq_on_r};

	logic [31:0] mode_w;
	logic [31:0] ch_mask_en_w;
	logic [31:0] ch_mask_dat_w;
	logic [31:0] ch_pol_w;
	logic [31:0] ch_poen_w;
	logic [31:0] inten_w;

	assign mode_w = merge(mode_cur);
	assign ch_mask_en_w = merge(ch_mask_en_cur);
	assign ch_mask_dat_w = merge(ch_mask_dat_cur);
	assign ch_pol_w = merge(ch_pol_cur);
	assign ch_poen_w = merge(ch_poen_cur);
	assign inten_w = merge(inten_cur);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			comp_mode_r <= 1'b0;
		end else if (wr_fire && avs_address == OFS_MODE_CTRL) begin
			comp_mode_r <= mode_w[COMP_MODE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mask_override_on_r <= CH_RESET;
			mask_level_bit_r <= CH_RESET;
		end else if (wr_fire) begin
			if (avs_address == OFS_MASK_ENABLE) begin
				mask_override_on_r <= ch_mask_en_w[5:0];
			end
			if (avs_address == OFS_MASK_DATA) begin
				mask_level_bit_r <= ch_mask_dat_w[5:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			polarity_flip_r <= CH_RESET;
			pin_drive_on_r <= CH_RESET;
		end else if (wr_fire) begin
			if (avs_address == OFS_POLARITY) begin
				polarity_flip_r <= ch_pol_w[5:0];
			end
			if (avs_address == OFS_PIN_ENABLE) begin
				pin_drive_on_r <= ch_poen_w[5:0];
			end
		end
	end

	// Odd enables are stored even in paired mode; only their read-back is hidden
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			down_match_irq_on_r <= CH_RESET;
			up_match_irq_on_r <= CH_RESET;
			period_point_irq_on_r <= 1'b0;
			zero_point_irq_on_r <= 1'b0;
		end else if (wr_fire && avs_address == OFS_INT_ENABLE) begin
			down_match_irq_on_r <= inten_w[DOWN_LSB +: 6];
			up_match_irq_on_r <= inten_w[UP_LSB +: 6];
			period_point_irq_on_r <= inten_w[PERIOD_BIT];
			zero_point_irq_on_r <= inten_w[ZERO_BIT];
		end
	end

	// ****************************************
	// Event flags and interrupt request
	// ****************************************
	logic [31:0] evt_vec;
	logic [31:0] clr_vec;
	logic [5:0] down_en_eff;
	logic [5:0] up_en_eff;
	logic [31:0] en_vec;

	assign evt_vec = {2'b00, down_match_evt, 2'b00, up_match_evt,
		7'h00, period_point_evt, 7'h00, zero_point_evt};
	assign clr_vec = (wr_fire && avs_address == OFS_INT_FLAGS) ?
		(wdata_m & FLAG_MASK) : REG_RESET;

	// Paired mode: an odd channel's enable gates the odd-slot events that
	// now belong to its even partner, so the pair raises the request
	// through either its own or its second enable.
	genvar p;
	generate
		for (p = 0; p < N; p += 2) begin : g_pair
			assign down_en_eff[p] = down_match_irq_on_r[p];
			assign up_en_eff[p] = up_match_irq_on_r[p];
			assign down_en_eff[p+1] = comp_mode_r ? down_match_irq_on_r[p+1]
				: down_match_irq_on_r[p+1];
			assign up_en_eff[p+1] = comp_mode_r ? up_match_irq_on_r[p+1]
				: up_match_irq_on_r[p+1];
		end
	endgenerate

	assign en_vec = {2'b00, down_en_eff, 2'b00, up_en_eff,
		7'h00, period_point_irq_on_r, 7'h00, zero_point_irq_on_r};

	event_flags #(
		.W(32)
	) u_flags (
		.ref_clk(ref_clk),
		.srst(srst),
		.evt(evt_vec & FLAG_MASK),
		.clr(clr_vec),
		.en(en_vec),
		.flags_r(flags),
		.irq_r(flag_irq)
	);

	// ****************************************
	// Output conditioning
	// ****************************************
	chan_cond_if #(.N(N)) cc ();

	assign cc.wave = wave_in;
	assign cc.mask_override_on = mask_override_on_r;
	assign cc.mask_level_bit = mask_level_bit_r;
	assign cc.polarity_flip = polarity_flip_r;
	assign cc.pin_drive_on = pin_drive_on_r;

	chan_conditioner #(
		.N(N)
	) u_cond (
		.cc(cc.path)
	);

	// Registered pins: one cycle of latency buys glitch-free outputs
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pwm_out_r <= CH_RESET;
			pwm_oe_r <= CH_RESET;
		end else begin
			pwm_out_r <= cc.pin_level;
			pwm_oe_r <= cc.pin_oe;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign avs_readdata = readdata_r;
	assign avs_waitrequest = waitrequest_r;
	assign pwm_out = pwm_out_r;
	assign pwm_oe = pwm_oe_r;
	assign irq = flag_irq;

endmodule : pwm_output_stage

// [tb/pwm_load_model.sv]
// External load on the PWM pins: resolves driven and floating wires
`timescale 1ns/1ps
module pwm_load_model (
	// Clock
	input wire logic ref_clk,
	// Pins from the stage
	input wire logic [5:0] pwm_out,
	input wire logic [5:0] pwm_oe,
	// Level seen by the load
	output logic [5:0] pin_seen
);
	logic [5:0] last_r = 6'h00;

	always_ff @(posedge ref_clk) begin
		last_r <= pin_seen;
	end

	// No pull on these wires: a floating pin toggles so no stale level passes
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin_seen[i] = pwm_oe[i] ? pwm_out[i] : ~last_r[i];
		end
	end
endmodule : pwm_load_model

// [tb/pwm_output_stage_checker.sv]
// Port-level assertions for the PWM output stage
`timescale 1ns/1ps
module pwm_output_stage_checker
	import pwm_out_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Events and pins
	input wire logic [5:0] wave_in,
	input wire logic [5:0] up_match_evt,
	input wire logic [5:0] down_match_evt,
	input wire logic period_point_evt,
	input wire logic zero_point_evt,
	input wire logic [5:0] pwm_out,
	input wire logic [5:0] pwm_oe,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic rack;
	logic wack;
	logic evt;
	assign rack = avs_read && !avs_waitrequest;
	assign wack = avs_write && !avs_waitrequest;
	assign evt = |{up_match_evt, down_match_evt, period_point_evt, zero_point_evt};

	a_ack_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus ack not one cycle");
	a_unmapped_zero: assert property (rack && !(avs_address inside {8'h00, 8'hb8,
		8'hbc, 8'hd4, 8'hd8, 8'he0, 8'he8}) |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_chan_reserved: assert property (rack && avs_address inside {8'hb8, 8'hbc, 8'hd4,
		8'hd8} |-> avs_readdata[31:6] == 26'h000_0000) else $error("reserved bits set");
	a_irq_layout: assert property (rack && avs_address inside {8'he0, 8'he8}
		|-> (avs_readdata & ~FLAG_MASK) == 32'h0000_0000) else $error("enable layout");
	a_irq_rise: assert property ($rose(irq) |-> $past(evt, 2) || $past(wack, 2))
		else $error("irq rose without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(wack, 2))
		else $error("irq fell without write");
	a_oe_cause: assert property ($changed(pwm_oe) |-> $past(wack, 2))
		else $error("output enable changed without write");
	a_out_cause: assert property ($changed(pwm_out) |-> $past(wave_in) != $past(wave_in, 2)
		|| $past(wack, 2) || $past(srst, 2)) else $error("pin changed without cause");
	a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data moved without read");

	c_irq: cover property ($rose(irq));
	c_read: cover property (rack && avs_address == 8'he0);
	c_oe: cover property ($rose(|pwm_oe));
endmodule : pwm_output_stage_checker

bind pwm_output_stage pwm_output_stage_checker chk_i (.ref_clk(ref_clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_in(wave_in),
	.up_match_evt(up_match_evt), .down_match_evt(down_match_evt),
	.period_point_evt(period_point_evt), .zero_point_evt(zero_point_evt),
	.pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));

// [tb/test_pwm_output_stage.sv]
// Self-checking bench for the PWM output stage
`timescale 1ns/1ps
module test_pwm_output_stage
	import pwm_out_pkg::*;
;
	localparam logic [7:0] MAP [7] = '{8'h00, 8'hb8, 8'hbc, 8'hd4, 8'hd8, 8'he0, 8'he8};
	localparam logic [5:0] WAVES [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [3:0] be_sel = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [5:0] wave_in = 6'h00;
	logic [31:0] ev = 32'h0000_0000;
	logic [5:0] pwm_out;
	logic [5:0] pwm_oe;
	logic [5:0] pin_seen;
	logic irq;
	logic [31:0] rd;
	int err_count = 0;
	int tests_run = 0;

	always #4 ref_clk = ~ref_clk;

	pwm_output_stage uut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .wave_in(wave_in),
		.up_match_evt(ev[21:16]), .down_match_evt(ev[29:24]),
		.period_point_evt(ev[8]), .zero_point_evt(ev[0]),
		.pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
	pwm_load_model load (.ref_clk(ref_clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
		.pin_seen(pin_seen));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Waits on the slave, never on a fixed latency
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be_sel;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rdchk

	task automatic pulse(input logic [31:0] e);
		@(posedge ref_clk);
		ev <= e;
		@(posedge ref_clk);
		ev <= 32'h0000_0000;
		repeat (3) @(posedge ref_clk);
	endtask : pulse

	task automatic close_out();
		$display("checks=%0d errors=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		close_out();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (MAP[i]) rdchk(MAP[i], 32'h0000_0000);
		bus(1'b1, 8'h40, 32'hffff_ffff);
		rdchk(8'h40, 32'h0000_0000);
		bus(1'b1, 8'hbc, 32'hffff_ffff);
		rdchk(8'hbc, 32'h0000_003f);
		bus(1'b1, 8'hd8, 32'h0000_003f);
		bus(1'b1, 8'hb8, 32'h0000_000f);
		bus(1'b1, 8'hbc, 32'h0000_0005);
		bus(1'b1, 8'hd4, 32'h0000_0021);
		chk({26'h0, pwm_oe}, 32'h0000_003f);
		// Mask on bits 3:0, flip on bits 0 and 5: every path gets a case
		foreach (WAVES[i]) begin
			wave_in <= WAVES[i];
			repeat (3) @(posedge ref_clk);
			chk({26'h0, pwm_out}, {26'h0, (6'h05 | (WAVES[i] & 6'h30)) ^ 6'h21});
			chk({26'h0, pin_seen}, {26'h0, (6'h05 | (WAVES[i] & 6'h30)) ^ 6'h21});
		end
		bus(1'b1, 8'hd8, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		chk({26'h0, pwm_oe}, 32'h0000_0000);
		// Undriven pins float: the load must see every one of them move
		rd = {26'h0, pin_seen};
		@(posedge ref_clk);
		chk({26'h0, pin_seen} ^ rd, 32'h0000_003f);
		for (int b = 0; b < 32; b++) begin
			if (FLAG_MASK[b]) begin
				bus(1'b1, 8'he0, 32'h0000_0001 << b);
				pulse(32'h0000_0001 << b);
				chk({31'h0, irq}, 32'h0000_0001);
				rdchk(8'he8, 32'h0000_0001 << b);
				bus(1'b1, 8'he8, 32'h0000_0001 << b);
				repeat (2) @(posedge ref_clk);
				chk({31'h0, irq}, 32'h0000_0000);
				bus(1'b1, 8'he0, 32'h0000_0000);
				pulse(32'h0000_0001 << b);
				chk({31'h0, irq}, 32'h0000_0000);
				bus(1'b1, 8'he8, 32'h0000_0001 << b);
			end
		end
		// Byte lane 0 only: the upper enables must stay clear
		be_sel = 4'h1;
		bus(1'b1, 8'he0, 32'hffff_ffff);
		be_sel = 4'hf;
		rdchk(8'he0, 32'h0000_0001);
		bus(1'b1, 8'h00, 32'h0000_0001);
		bus(1'b1, 8'he0, 32'h0202_0000);
		rdchk(8'he0, 32'h0000_0000);
		pulse(32'h0202_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		bus(1'b1, 8'he8, 32'h0202_0000);
		bus(1'b1, 8'he0, 32'h3f3f_0101);
		rdchk(8'he0, 32'h1515_0101);
		bus(1'b1, 8'h00, 32'h0000_0000);
		rdchk(8'he0, 32'h3f3f_0101);
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		rdchk(8'he0, 32'h0000_0000);
		close_out();
	end
endmodule : test_pwm_output_stage
